/* design/conv_thresh_pkg.sv */
// constants and types shared by the input threshold configuration block
package conv_thresh_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SWITCHING_RATE = 8'h33;
    localparam logic [7:0] ADDR_START_THRESH   = 8'h35;
    localparam logic [7:0] ADDR_STOP_THRESH    = 8'h36;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int RATE_W  = 2;
    localparam int START_W = 2;
    localparam int STOP_W  = 3;
    localparam int STOP_LEVELS = 6;
    localparam int START_LEVELS = 3;

    localparam logic [7:0] REG_ZERO = 8'h00;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [START_W-1:0] START_CODE_SUPPLY = 2'h3;
    localparam logic [STOP_W-1:0]  STOP_CODE_SUPPLY  = 3'h7;
    localparam logic [STOP_W-1:0]  STOP_CODE_LOW_ALT = 3'h6;
    localparam logic [STOP_W-1:0]  STOP_CODE_LOW     = 3'h0;

    // switching rate in kHz per code
    localparam int RATE_KHZ_W = 11;
    localparam logic [RATE_KHZ_W-1:0] RATE_KHZ_0 = 11'h258;
    localparam logic [RATE_KHZ_W-1:0] RATE_KHZ_1 = 11'h320;
    localparam logic [RATE_KHZ_W-1:0] RATE_KHZ_2 = 11'h3E8;
    localparam logic [RATE_KHZ_W-1:0] RATE_KHZ_3 = 11'h4B0;

    typedef enum logic [2:0]
    {
        MODE_ALWAYS    = 3'h0,
        MODE_HOST_ONLY = 3'h1,
        MODE_PIN_ONLY  = 3'h2,
        MODE_HOST_PIN  = 3'h3
    } on_off_mode_e;

    // ------------------------------------------------------------
    // comparator bundle, all synchronous to clk_i
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [START_LEVELS-1:0] vin_above_start; // 10 V, 9 V, 8 V
        logic                    vin_above_2p55;
        logic                    bias_above_3p8;
        logic [STOP_LEVELS-1:0]  vin_below_stop;  // 9.5, 8.5, 7.5, 6.5, 5.5, 4.2 V
        logic                    vin_le_2p3;
        logic                    drv_le_3p4;
    } comparators_s;

    typedef struct packed
    {
        logic [RATE_W-1:0]  rate;
        logic [START_W-1:0] start;
        logic [STOP_W-1:0]  stop;
    } thresh_cfg_s;

endpackage : conv_thresh_pkg

/* design/thresh_select.sv */
// picks the active start and stop comparator results from the programmed codes
`timescale 1ns/1ps
`default_nettype none
module thresh_select
    import conv_thresh_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire thresh_cfg_s  cfg_i,
    input  wire comparators_s cmp_i,
    output logic              above_start_o,
    output logic              below_stop_o
);

    // ------------------------------------------------------------
    // start level select
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            above_start_o <= 1'b0;
        else if (cfg_i.start == START_CODE_SUPPLY)
            above_start_o <= cmp_i.vin_above_2p55 & cmp_i.bias_above_3p8;
        else
            above_start_o <= cmp_i.vin_above_start[cfg_i.start];
    end

    // ------------------------------------------------------------
    // stop level select
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            below_stop_o <= 1'b0;
        else if (cfg_i.stop == STOP_CODE_SUPPLY)
            below_stop_o <= cmp_i.vin_le_2p3 | cmp_i.drv_le_3p4;
        else if (cfg_i.stop == STOP_CODE_LOW)
            below_stop_o <= cmp_i.vin_below_stop[STOP_CODE_LOW_ALT - 3'h1];
        else
            below_stop_o <= cmp_i.vin_below_stop[cfg_i.stop - 3'h1];
    end

endmodule : thresh_select
`default_nettype wire

/* design/converter_input_threshold_config.sv */
// switching rate and input start/stop threshold registers with undervoltage flag
//
// What this block does
// - The two-bit rate field decodes to 0.6, 0.8, 1.0 or 1.2 MHz for codes 0 to 3.
// - Unused upper bits of the three registers read zero and ignore writes.
// - Fields load from the nonvolatile backup after reset and host writes take effect at once.
// - Start codes 0, 1 and 2 select start levels of 10 V, 9 V and 8 V.
// - Start code 3 permits conversion only with input above 2.55 V and bias above 3.8 V.
// - Conversion may begin only once the input is above the selected start level.
// - After power-on reset the undervoltage flag stays masked until the input first rises above the start level.
// - Once unmasked the flag stays unmasked; pin toggles and store or restore do not remask it.
// - The three-bit stop field decodes to 4.2, 9.5, 8.5, 7.5, 6.5, 5.5 and 4.2 V for codes 0 to 6.
// - Stop code 7 stops conversion when input is at or below 2.3 V or driver supply at or below 3.4 V.
// - With enable met and input below the stop level, conversion turns off and, once unmasked, the undervoltage flag is set.
// - The enable condition follows the mode: always, host only, pin only, or host and pin together.
`timescale 1ns/1ps
`default_nettype none
module converter_input_threshold_config
    import conv_thresh_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    // register access from the serial engine
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    output logic [7:0]                 reg_rdata_o,
    output logic                       reg_rvalid_o,
    // nonvolatile defaults
    input  wire thresh_cfg_s           nvm_cfg_i,
    // enable sources
    input  wire logic [2:0]            on_off_mode_i,
    input  wire logic                  host_on_i,
    input  wire logic                  en_pin_i,
    // analog comparator results
    input  wire comparators_s          cmp_i,
    // status clear from the fault logic
    input  wire logic                  clear_faults_i,
    // outputs to the power stage
    output logic [RATE_W-1:0]          switching_rate_code_o,
    output logic [RATE_KHZ_W-1:0]      switching_rate_khz_o,
    output logic                       conversion_on_o,
    output logic                       input_undervoltage_flag_o
);

    thresh_cfg_s cfg_q;
    logic        load_pending_q;
    logic        unmasked_q;
    logic        above_start;
    logic        below_stop;
    logic        enable_met;
    logic        wr_rate;
    logic        wr_start;
    logic        wr_stop;
    logic        stop_now;
    logic        uv_set;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [RATE_KHZ_W-1:0] rate_khz(input logic [RATE_W-1:0] code);
        unique case (code)
            2'h0: rate_khz = RATE_KHZ_0;
            2'h1: rate_khz = RATE_KHZ_1;
            2'h2: rate_khz = RATE_KHZ_2;
            2'h3: rate_khz = RATE_KHZ_3;
        endcase
    endfunction : rate_khz

    function automatic logic enable_of(input logic [2:0] mode, input logic host, input logic pin);
        case (mode)
            MODE_ALWAYS:    enable_of = 1'b1;
            MODE_HOST_ONLY: enable_of = host;
            MODE_PIN_ONLY:  enable_of = pin;
            MODE_HOST_PIN:  enable_of = host & pin;
            default:        enable_of = 1'b0;
        endcase
    endfunction : enable_of

    assign enable_met = enable_of(on_off_mode_i, host_on_i, en_pin_i);

    // ------------------------------------------------------------
    // register address decode
    // ------------------------------------------------------------
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
        addr_is = (addr == offset);
    endfunction : addr_is

    function automatic logic [7:0] read_view(input logic [7:0] addr, input thresh_cfg_s cfg);
        if (addr_is(addr, ADDR_SWITCHING_RATE))
            read_view = {{(8-RATE_W){1'b0}}, cfg.rate};
        else if (addr_is(addr, ADDR_START_THRESH))
            read_view = {{(8-START_W){1'b0}}, cfg.start};
        else if (addr_is(addr, ADDR_STOP_THRESH))
            read_view = {{(8-STOP_W){1'b0}}, cfg.stop};
        else
            read_view = REG_ZERO;
    endfunction : read_view

    assign wr_rate  = reg_wr_i && addr_is(reg_addr_i, ADDR_SWITCHING_RATE);
    assign wr_start = reg_wr_i && addr_is(reg_addr_i, ADDR_START_THRESH);
    assign wr_stop  = reg_wr_i && addr_is(reg_addr_i, ADDR_STOP_THRESH);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            load_pending_q <= 1'b1;
        else
            load_pending_q <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cfg_q <= '0;
        else if (load_pending_q)
            cfg_q <= nvm_cfg_i;
        else
        begin
            if (wr_rate)
                cfg_q.rate <= reg_wdata_i[RATE_W-1:0];
            if (wr_start)
                cfg_q.start <= reg_wdata_i[START_W-1:0];
            if (wr_stop)
                cfg_q.stop <= reg_wdata_i[STOP_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            reg_rdata_o  <= REG_ZERO;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
            begin
                reg_rdata_o <= read_view(reg_addr_i, cfg_q);
            end
        end
    end

    // ------------------------------------------------------------
    // switching rate outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            switching_rate_code_o <= '0;
            switching_rate_khz_o  <= RATE_KHZ_0;
        end
        else
        begin
            switching_rate_code_o <= cfg_q.rate;
            switching_rate_khz_o  <= rate_khz(cfg_q.rate);
        end
    end

    // ------------------------------------------------------------
    // threshold comparison
    // ------------------------------------------------------------
    thresh_select u_thresh_select
    (
        .clk_i         (clk_i),
        .rst_b_i       (rst_b_i),
        .cfg_i         (cfg_q),
        .cmp_i         (cmp_i),
        .above_start_o (above_start),
        .below_stop_o  (below_stop)
    );

    // ------------------------------------------------------------
    // stop and flag conditions
    // ------------------------------------------------------------
    assign stop_now = !enable_met || below_stop;
    assign uv_set   = unmasked_q && enable_met && below_stop;

    // ------------------------------------------------------------
    // conversion control
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            conversion_on_o <= 1'b0;
        else if (stop_now)
            conversion_on_o <= 1'b0;
        else if (above_start)
            conversion_on_o <= 1'b1;
    end

    // ------------------------------------------------------------
    // undervoltage flag and its mask
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            unmasked_q <= 1'b0;
        else if (above_start)
            unmasked_q <= 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            input_undervoltage_flag_o <= 1'b0;
        else if (uv_set)
            input_undervoltage_flag_o <= 1'b1;
        else if (clear_faults_i)
            input_undervoltage_flag_o <= 1'b0;
    end

endmodule : converter_input_threshold_config
`default_nettype wire

/* verification/conv_thresh_sva.sv */
// port assertions for the threshold configuration block
`timescale 1ns/1ps
`default_nettype none
module conv_thresh_chk
    import conv_thresh_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    input  wire logic [7:0]            reg_rdata_o,
    input  wire logic                  reg_rvalid_o,
    input  wire logic [2:0]            on_off_mode_i,
    input  wire logic                  clear_faults_i,
    input  wire logic [RATE_W-1:0]     switching_rate_code_o,
    input  wire logic [RATE_KHZ_W-1:0] switching_rate_khz_o,
    input  wire logic                  conversion_on_o,
    input  wire logic                  input_undervoltage_flag_o
);
    // ----------
    // relations
    // ----------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic [1:0]            wr_rate = reg_wdata_i[1:0];
    wire logic [RATE_KHZ_W-1:0] khz_exp = switching_rate_code_o[1]
        ? (switching_rate_code_o[0] ? RATE_KHZ_3 : RATE_KHZ_2)
        : (switching_rate_code_o[0] ? RATE_KHZ_1 : RATE_KHZ_0);
    property p_rd_answer; reg_rd_i |=> reg_rvalid_o; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rv_pulse; !reg_rd_i |=> !reg_rvalid_o; endproperty
    a_rv_pulse: assert property (p_rv_pulse) else $error("stray read valid");
    property p_upper_zero; reg_rvalid_o |-> reg_rdata_o[7:3] == 5'h00; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
    property p_rate_rd; reg_rd_i && reg_addr_i == ADDR_SWITCHING_RATE
        |=> reg_rdata_o == {6'h00, switching_rate_code_o}; endproperty
    a_rate_rd: assert property (p_rate_rd) else $error("rate readback differs");
    property p_khz; switching_rate_khz_o == khz_exp; endproperty
    a_khz: assert property (p_khz) else $error("rate decode wrong");
    property p_rate_wr; reg_wr_i && reg_addr_i == ADDR_SWITCHING_RATE
        |=> ##1 switching_rate_code_o == $past(wr_rate, 2); endproperty
    a_rate_wr: assert property (p_rate_wr) else $error("rate write not applied");
    property p_mode_off; on_off_mode_i[2] [*3] |-> !conversion_on_o; endproperty
    a_mode_off: assert property (p_mode_off) else $error("on in reserved mode");
    property p_flag_off; $rose(input_undervoltage_flag_o) |-> !conversion_on_o; endproperty
    a_flag_off: assert property (p_flag_off) else $error("flag set while on");
    property p_flag_hold; input_undervoltage_flag_o && !clear_faults_i
        |=> input_undervoltage_flag_o; endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
endmodule : conv_thresh_chk
bind converter_input_threshold_config conv_thresh_chk u_chk
(
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .on_off_mode_i(on_off_mode_i), .clear_faults_i(clear_faults_i),
    .switching_rate_code_o(switching_rate_code_o), .switching_rate_khz_o(switching_rate_khz_o),
    .conversion_on_o(conversion_on_o), .input_undervoltage_flag_o(input_undervoltage_flag_o)
);
`default_nettype wire

/* verification/reg_host.sv */
// host model issuing byte writes and reads
`timescale 1ns/1ps
`default_nettype none
module reg_host
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    // ----------
    // byte transfers
    // ----------
    initial {wr_o, rd_o, addr_o, wdata_o} = '0;
    // reverse start and stop settings pass unchecked
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
        v = rvalid_i;
    endtask : rd
endmodule : reg_host
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the threshold configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import conv_thresh_pkg::*;
;
    logic                  clk_i = 1'b0, rst_b_i = 1'b0, hon = 1'b0, pin = 1'b0, clr = 1'b0;
    logic                  wr, rd, rvalid, con, uvf, v;
    logic [7:0]            addr, wdata, rdata, d;
    logic [RATE_W-1:0]     rcode;
    logic [RATE_KHZ_W-1:0] khz;
    logic [2:0]            mode = 3'h0, st, sp;
    thresh_cfg_s           nvm = '0;
    comparators_s          cmp = '0;
    logic [7:0]            adr [3] = '{ADDR_SWITCHING_RATE, ADDR_START_THRESH, ADDR_STOP_THRESH};
    logic [7:0]            msk [3] = '{8'h03, 8'h03, 8'h07};
    logic [7:0]            mdl [3];
    int                    err_count = 0, checked = 0;
    reg_host host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr), .rd_o(rd),
                   .addr_o(addr), .wdata_o(wdata));
    converter_input_threshold_config dut
    (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .nvm_cfg_i(nvm),
        .on_off_mode_i(mode), .host_on_i(hon), .en_pin_i(pin), .cmp_i(cmp), .clear_faults_i(clr),
        .switching_rate_code_o(rcode), .switching_rate_khz_o(khz), .conversion_on_o(con),
        .input_undervoltage_flag_o(uvf)
    );
    // ----------
    // tasks
    // ----------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic put(input int i, input logic [7:0] b);
        host.wr(adr[i], b);
        mdl[i] = b & msk[i];
    endtask : put
    task automatic look(input int i);
        host.rd(adr[i], d, v);
        chk(v, 1'b1);
        chk(d, mdl[i]);
    endtask : look
    task automatic nvm_check;
        mdl[0] = {6'h00, nvm.rate};
        mdl[1] = {6'h00, nvm.start};
        mdl[2] = {5'h00, nvm.stop};
        foreach (adr[i]) look(i);
    endtask : nvm_check
    // up selects the start level alone, else every other start input; dn likewise for stop
    task automatic sense(input logic up, input logic dn);
        int k;
        k = (sp == 3'h0 || sp == 3'h6) ? 5 : sp - 1;
        cmp.vin_above_start = (up ? 3'h0 : 3'h7) ^ (st == 3'h3 ? 3'h0 : 3'h1 << st);
        cmp.vin_above_2p55 = up;
        cmp.bias_above_3p8 = 1'b1;
        cmp.vin_below_stop = (sp == 3'h7) ? 6'h3F : (dn ? 6'h00 : 6'h3F) ^ (6'h01 << k);
        cmp.vin_le_2p3 = (sp != 3'h7) && !dn;
        cmp.drv_le_3p4 = (sp == 3'h7) ? dn : !dn;
    endtask : sense
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // ----------
    // sequence
    // ----------
    initial forever #2 clk_i = ~clk_i;
    initial
    begin
        #400000;
        err_count++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(38565));
        nvm = thresh_cfg_s'(7'($urandom));
        step(8);
        rst_b_i = 1'b1;
        step(2);
        nvm_check();
        st = 3'h0;
        sp = 3'h0;
        put(1, 8'hFC);
        put(2, 8'hF8);
        sense(1'b0, 1'b1);
        step(3);
        chk(uvf, 1'b0);
        for (int s = 0; s < 4; s++)
        begin
            st = 3'(s);
            put(1, {6'($urandom), 2'(s)});
            look(1);
            sense(1'b0, 1'b1);
            step(3);
            sense(1'b0, 1'b0);
            step(3);
            chk(con, 1'b0);
            sense(1'b1, 1'b0);
            step(3);
            chk(con, 1'b1);
        end
        for (int j = 0; j < 32; j++)
        begin
            mode = 3'(j / 4);
            hon = j[0];
            pin = j[1];
            step(3);
            chk(con, mode == 0 || (mode == 1 && hon) || (mode == 2 && pin) || (mode == 3 && hon && pin));
        end
        mode = 3'h2;
        for (int s = 0; s < 8; s++)
        begin
            sp = 3'(s);
            put(2, {5'($urandom), 3'(s)});
            look(2);
            sense(1'b1, 1'b0);
            clr = 1'b1;
            step(1);
            clr = 1'b0;
            step(3);
            chk({con, uvf}, 2'b10);
            sense(1'b1, 1'b1);
            step(3);
            chk({con, uvf}, 2'b01);
        end
        for (int r = 0; r < 4; r++)
        begin
            put(0, {6'($urandom), 2'(r)});
            step(2);
            chk({rcode, khz}, {2'(r), 11'(600 + 200 * r)});
            look(0);
        end
        host.rd(8'h34, d, v);
        chk({v, d}, 9'h100);
        rst_b_i = 1'b0;
        step(2);
        chk({con, uvf, khz}, {2'b00, RATE_KHZ_0});
        cmp = comparators_s'(12'h0FF);
        rst_b_i = 1'b1;
        step(2);
        nvm_check();
        step(3);
        chk({con, uvf}, 2'b00);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
